// File: src/slot_status_devcap2_regs.v
// slot_status_devcap2_regs.v: hot-plug slot status, device caps/control 2 and link caps 2 over apb
// assumes slot sensors and strap inputs are asynchronous; pulse events are at least 3 pclk long
//
// Behaviour
// - The attention-button flag at bit 16 sets on a press, resets to zero and clears on a write of one.
// - The power-fault flag at bit 17 sets on a detected fault, resets to zero and clears on a write of one.
// - The latch-changed flag at bit 18 sets on a latch sensor change, resets to zero and ignores writes.
// - The presence-changed flag at bit 19 sets on a presence change, resets to zero and clears on a write of one.
// - The command-completed flag at bit 20 sets when a command finishes, resets to zero and clears on a write of one.
// - Bit 21 mirrors the latch sensor, zero closed and one open, resetting to zero.
// - Bit 22 reports card presence, zero empty and one present, resetting to zero.
// - With no slot implemented the presence state bit reads one once its synchroniser settles, but zero straight after reset.
// - The link-active-changed flag at bit 24 sets on any change of link-active and clears on a write of one.
// - Device capabilities 2 bit 11 reads one, bit 12 resets to zero and takes a loaded value, and other unlisted fields read zero.
// - Bits 19:18 report buffer flush support, reset to zero, replaceable by a loaded value.
// - Device control 2 has read-write bit 10 and bits 14:13, resetting to zero, all else reads zero.
// - A hot-plug interrupt fires only when the event enable and the global hot-plug enable are both set.
//
// Chosen here: the APB slave port.
`include "slot_regs_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module slot_status_devcap2_regs (
  input wire pclk, // 100 mhz bus clock
  input wire presetn, // async reset, active low
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb direction
  input wire [7:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output reg [31:0] prdata, // apb read data
  output reg pready, // apb ready
  output reg pslverr, // apb error, unmapped address
  input wire button_in, // attention button pressed
  input wire pwr_fault_in, // power fault detected
  input wire latch_open_in, // retention latch sensor, 1 open
  input wire card_present_in, // card presence sensor
  input wire cmd_done_in, // hot-plug command finished
  input wire link_active_in, // data link layer link active
  input wire slot_impl_in, // slot implemented capability
  output reg hp_irq, // hot-plug interrupt from slot control
  output reg irq // summary interrupt from status and mask
);

  // register map, byte offsets on the 8-bit paddr:
  //   d4 slot control enables, d8 slot status flags and live sensor state
  //   e4 device capabilities 2, e8 device control 2 with status 2 above it
  //   ec link capabilities 2, all zero
  //   f0 summary status (w1c), f4 summary mask, both in the six-bit event layout
  //   f8 load register standing in for the serial-bus or eeprom override
  // any other offset answers with pslverr, reads zero and drops the write
  // the summary pair duplicates the slot flags for a plain level interrupt,
  // so clearing one of them never clears the other

  // sensor index into the synchroniser vector
  localparam S_BUT = 0;
  localparam S_PWR = 1;
  localparam S_LAT = 2;
  localparam S_PRS = 3;
  localparam S_CMD = 4;
  localparam S_DLL = 5;
  localparam S_IMP = 6;
  localparam NS = 7;

  wire [NS-1:0] raw_in;
  assign raw_in = {slot_impl_in, link_active_in, cmd_done_in, card_present_in,
                   latch_open_in, pwr_fault_in, button_in};

  // three-flop synchronisers; a level counts once stages two and three agree
  // the slot-implemented stages leave reset high, so presence state reads zero
  // straight after reset instead of the forced one of a slotless port
  // a pin change reaches stable_r four edges later; shorter pulses may be lost
  localparam [NS-1:0] SYNC_INIT = `SYNC_RESET;
  reg [NS-1:0] sync1_r;
  reg [NS-1:0] sync2_r;
  reg [NS-1:0] sync3_r;
  reg [NS-1:0] stable_r;
  reg [NS-1:0] stable_d_r;
  genvar g;
  generate
    for (g = 0; g < NS; g = g + 1) begin : g_sync
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_r[g] <= SYNC_INIT[g];
          sync2_r[g] <= SYNC_INIT[g];
          sync3_r[g] <= SYNC_INIT[g];
          stable_r[g] <= SYNC_INIT[g];
          stable_d_r[g] <= SYNC_INIT[g];
        end else begin
          sync1_r[g] <= raw_in[g];
          sync2_r[g] <= sync1_r[g];
          sync3_r[g] <= sync2_r[g];
          if (sync2_r[g] == sync3_r[g]) begin
            stable_r[g] <= sync3_r[g];
          end
          stable_d_r[g] <= stable_r[g];
        end
      end
    end
  endgenerate

  // event pulses: rising edge for button/fault/command, any edge for latch/presence/link
  // edges come from the agreed level, so a glitch shorter than two clocks is no event
  wire ev_but;
  wire ev_pwr;
  wire ev_lat;
  wire ev_prs;
  wire ev_cmd;
  wire ev_dll;
  assign ev_but = stable_r[S_BUT] & ~stable_d_r[S_BUT];
  assign ev_pwr = stable_r[S_PWR] & ~stable_d_r[S_PWR];
  assign ev_lat = stable_r[S_LAT] ^ stable_d_r[S_LAT];
  assign ev_prs = stable_r[S_PRS] ^ stable_d_r[S_PRS];
  assign ev_cmd = stable_r[S_CMD] & ~stable_d_r[S_CMD];
  assign ev_dll = stable_r[S_DLL] ^ stable_d_r[S_DLL];

  // apb decode; one wait state, so every access spans two psel&penable edges
  // acc_first marks the opening edge, acc_last the edge at which pready is high
  // writes land once, at acc_last, so a w1c clear also wipes an event
  // that set its flag at the opening edge of the same access
  wire acc;
  wire acc_first;
  wire acc_last;
  wire wr;
  wire rd;
  assign acc = psel & penable;
  assign acc_first = acc & ~pready;
  assign acc_last = acc & pready;
  assign wr = acc_last & pwrite;
  assign rd = acc_first & ~pwrite;

  // address decode; offsets compare whole, so misaligned addresses miss

  wire hit_slot;
  wire hit_cap;
  wire hit_ctl;
  wire hit_lcap;
  wire hit_sctl;
  wire hit_ist;
  wire hit_imsk;
  wire hit_strap;
  wire mapped;
  assign hit_slot = (paddr == `OFF_SLOT_WORD);
  assign hit_cap = (paddr == `OFF_DEVCAP2);
  assign hit_ctl = (paddr == `OFF_DEVCTL2);
  assign hit_lcap = (paddr == `OFF_LINKCAP2);
  assign hit_sctl = (paddr == `OFF_SLOT_CTL);
  assign hit_ist = (paddr == `OFF_IRQ_STATUS);
  assign hit_imsk = (paddr == `OFF_IRQ_MASK);
  assign hit_strap = (paddr == `OFF_STRAP);
  assign mapped = hit_slot | hit_cap | hit_ctl | hit_lcap | hit_sctl | hit_ist | hit_imsk | hit_strap;

  // slot status sticky flags
  reg flag_but_r;
  reg flag_pwr_r;
  reg flag_lat_r;
  reg flag_prs_r;
  reg flag_cmd_r;
  reg flag_dll_r;
  wire slot_w1c;
  assign slot_w1c = wr & hit_slot;

  // per-flag clear strobes; a zero in the write data leaves its flag alone
  wire clr_but;
  wire clr_pwr;
  wire clr_prs;
  wire clr_cmd;
  wire clr_dll;
  assign clr_but = slot_w1c & pwdata[`B_BUTTON];
  assign clr_pwr = slot_w1c & pwdata[`B_PWR_FAULT];
  assign clr_prs = slot_w1c & pwdata[`B_PRES_CHG];
  assign clr_cmd = slot_w1c & pwdata[`B_CMD_DONE];
  assign clr_dll = slot_w1c & pwdata[`B_DLL_CHG];

  // set wins over clear so no event is lost at the edge where a clearing write lands
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_but_r <= 1'b0;
      flag_pwr_r <= 1'b0;
      flag_lat_r <= 1'b0;
      flag_prs_r <= 1'b0;
      flag_cmd_r <= 1'b0;
      flag_dll_r <= 1'b0;
    end else begin
      flag_but_r <= ev_but | (flag_but_r & ~clr_but);
      flag_pwr_r <= ev_pwr | (flag_pwr_r & ~clr_pwr);
      // the latch flag has no software clear; only a reset returns it to zero
      flag_lat_r <= ev_lat | flag_lat_r;
      flag_prs_r <= ev_prs | (flag_prs_r & ~clr_prs);
      flag_cmd_r <= ev_cmd | (flag_cmd_r & ~clr_cmd);
      flag_dll_r <= ev_dll | (flag_dll_r & ~clr_dll);
    end
  end

  // slot control enables (low half of d8 word lives at its own offset here)
  // only the enable bits are kept; indicator and power-control fields live elsewhere
  reg [15:0] slot_ctl_r;
  reg ltr_en_r;
  reg [1:0] obff_en_r;
  reg [1:0] obff_sup_r;
  reg fc_ltr_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_ctl_r <= `CTL_RESET;
      ltr_en_r <= 1'b0;
      obff_en_r <= `OBFF_RESET;
      obff_sup_r <= `OBFF_RESET;
      fc_ltr_r <= 1'b0;
    end else begin
      if (wr && hit_sctl) begin
        slot_ctl_r <= pwdata[15:0] & `SLOT_CTL_MASK;
      end
      if (wr && hit_ctl) begin
        ltr_en_r <= pwdata[`B_LTR_EN];
        obff_en_r <= pwdata[`B_OBFF_EN_HI:`B_OBFF_EN_LO];
      end
      // management load port stands in for the serial bus / eeprom override
      if (wr && hit_strap) begin
        obff_sup_r <= pwdata[`B_OBFF_HI:`B_OBFF_LO];
        fc_ltr_r <= pwdata[`B_FC_LTR];
      end
    end
  end

  // generic interrupt status (w1c) and mask, bit order: but pwr lat prs cmd dll
  wire [`N_EVT-1:0] ev_vec;
  assign ev_vec = {ev_dll, ev_cmd, ev_prs, ev_lat, ev_pwr, ev_but};
  // summary clears follow the same set-wins order as the slot flags
  wire [`N_EVT-1:0] ist_clr;
  assign ist_clr = (wr && hit_ist) ? pwdata[`N_EVT-1:0] : `EVT_ZERO;
  reg [`N_EVT-1:0] ist_r;
  reg [`N_EVT-1:0] imsk_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_r <= `EVT_ZERO;
      imsk_r <= `EVT_ZERO;
    end else begin
      ist_r <= ev_vec | (ist_r & ~ist_clr);
      if (wr && hit_imsk) begin
        imsk_r <= pwdata[`N_EVT-1:0];
      end
    end
  end

  // per-event hot-plug requests, each gated by its own enable in slot control
  wire hp_but;
  wire hp_pwr;
  wire hp_lat;
  wire hp_prs;
  wire hp_cmd;
  wire hp_dll;
  assign hp_but = flag_but_r & slot_ctl_r[`C_BUTTON_EN];
  assign hp_pwr = flag_pwr_r & slot_ctl_r[`C_PWR_FAULT_EN];
  assign hp_lat = flag_lat_r & slot_ctl_r[`C_LATCH_EN];
  assign hp_prs = flag_prs_r & slot_ctl_r[`C_PRES_EN];
  assign hp_cmd = flag_cmd_r & slot_ctl_r[`C_CMD_EN];
  assign hp_dll = flag_dll_r & slot_ctl_r[`C_DLL_EN];

  // the global enable gates them all; the flags themselves stay set while it is low
  wire hp_any;
  assign hp_any = slot_ctl_r[`C_HP_IRQ_EN] & (hp_but | hp_pwr | hp_lat | hp_prs | hp_cmd | hp_dll);

  // registered interrupt outputs
  // one clock behind the flags, so both outputs come straight from flip-flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hp_irq <= 1'b0;
      irq <= 1'b0;
    end else begin
      hp_irq <= hp_any;
      irq <= |(ist_r & imsk_r);
    end
  end

  // slot status word; bits 15:0, 23 and 31:25 stay zero
  reg [31:0] slot_word;
  always @* begin
    slot_word = `WORD_ZERO;
    slot_word[`B_BUTTON] = flag_but_r;
    slot_word[`B_PWR_FAULT] = flag_pwr_r;
    slot_word[`B_LATCH_CHG] = flag_lat_r;
    slot_word[`B_PRES_CHG] = flag_prs_r;
    slot_word[`B_CMD_DONE] = flag_cmd_r;
    slot_word[`B_LATCH_ST] = stable_r[S_LAT];
    // a port without a slot reports a card as present once its synchroniser settles after reset
    slot_word[`B_PRES_ST] = stable_r[S_PRS] | ~stable_r[S_IMP];
    slot_word[`B_DLL_CHG] = flag_dll_r;
  end

  // device capabilities 2; only the support bit and the loadable fields are live
  reg [31:0] cap_word;
  always @* begin
    cap_word = `WORD_ZERO;
    cap_word[`B_LTR_SUP] = 1'b1;
    cap_word[`B_FC_LTR] = fc_ltr_r;
    cap_word[`B_OBFF_HI:`B_OBFF_LO] = obff_sup_r;
  end

  // device control 2 in the low half; device status 2 above it reads zero
  reg [31:0] ctl_word;
  always @* begin
    ctl_word = `WORD_ZERO;
    ctl_word[`B_LTR_EN] = ltr_en_r;
    ctl_word[`B_OBFF_EN_HI:`B_OBFF_EN_LO] = obff_en_r;
  end

  // read mux; unmapped offsets and reserved bits read zero
  reg [31:0] rdata_nxt;
  always @* begin
    rdata_nxt = `WORD_ZERO;
    if (hit_slot) begin
      rdata_nxt = slot_word;
    end else if (hit_cap) begin
      rdata_nxt = cap_word;
    end else if (hit_ctl) begin
      rdata_nxt = ctl_word;
    end else if (hit_sctl) begin
      rdata_nxt[15:0] = slot_ctl_r;
    end else if (hit_ist) begin
      rdata_nxt[`N_EVT-1:0] = ist_r;
    end else if (hit_imsk) begin
      rdata_nxt[`N_EVT-1:0] = imsk_r;
    end else if (hit_strap) begin
      rdata_nxt[`B_FC_LTR] = fc_ltr_r;
      rdata_nxt[`B_OBFF_HI:`B_OBFF_LO] = obff_sup_r;
    end
  end

  // one-wait answer: pready rises the cycle after the access phase opens
  // prdata is taken at the opening edge and holds until the next read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `WORD_ZERO;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= acc_first;
      pslverr <= acc_first & ~mapped;
      if (rd) begin
        prdata <= rdata_nxt;
      end
    end
  end

endmodule // slot_status_devcap2_regs

`default_nettype wire

// File: common/slot_regs_defs.vh
// slot_regs_defs.vh: offsets, field positions and reset values for the slot status block
// assumes inclusion by bare name from the design file
`ifndef SLOT_REGS_DEFS_VH
`define SLOT_REGS_DEFS_VH

// register byte offsets
`define OFF_SLOT_WORD 8'hd8
`define OFF_DEVCAP2 8'he4
`define OFF_DEVCTL2 8'he8
`define OFF_LINKCAP2 8'hec
`define OFF_SLOT_CTL 8'hd4
`define OFF_IRQ_STATUS 8'hf0
`define OFF_IRQ_MASK 8'hf4
`define OFF_STRAP 8'hf8

// slot status field positions (within the d8 word)
`define B_BUTTON 16
`define B_PWR_FAULT 17
`define B_LATCH_CHG 18
`define B_PRES_CHG 19
`define B_CMD_DONE 20
`define B_LATCH_ST 21
`define B_PRES_ST 22
`define B_DLL_CHG 24

// slot control enable positions
`define C_BUTTON_EN 0
`define C_PWR_FAULT_EN 1
`define C_LATCH_EN 2
`define C_PRES_EN 3
`define C_CMD_EN 4
`define C_HP_IRQ_EN 5
`define C_DLL_EN 12
`define SLOT_CTL_MASK 16'h103f

// capability and control fields
`define B_LTR_SUP 11
`define B_FC_LTR 12
`define B_OBFF_LO 18
`define B_OBFF_HI 19
`define B_LTR_EN 10
`define B_OBFF_EN_LO 13
`define B_OBFF_EN_HI 14

// interrupt status bit count and reset values
`define N_EVT 6
`define EVT_ZERO 6'h00
`define CTL_RESET 16'h0000
`define OBFF_RESET 2'h0
`define WORD_ZERO 32'h00000000
`define SYNC_ZERO 3'h0
// synchroniser reset pattern: only the slot-implemented stage starts high
`define SYNC_RESET 7'h40
`endif

// File: verif/slot_sensors.sv
// slot_sensors: behavioural hot-plug sensors on the far side of the block
// assumes the bench calls its tasks, one at a time, from a single process
`timescale 1ns/1ps
`default_nettype none
module slot_sensors (
  input wire logic pclk, // bus clock
  output logic [6:0] sens // button,fault,latch,card,cmd,link,slot_impl
);
  // slot implemented from power-up, all sensors idle
  initial sens = 7'h40;
  // pulse held 4 clocks, past the 3-clock minimum of the sampler
  task automatic pulse(input int k);
    @(posedge pclk) sens[k] <= 1'b1;
    repeat (4) @(posedge pclk);
    sens[k] <= 1'b0;
  endtask
  // level sensors just move and stay
  task automatic setl(input int k, input logic v);
    @(posedge pclk) sens[k] <= v;
  endtask
endmodule // slot_sensors
`default_nettype wire

// File: verif/slot_status_devcap2_regs_checker.sv
// checker for the slot status register block, watches top ports only
// assumes apb master holds paddr and pwrite through the pready cycle
`timescale 1ns/1ps
`default_nettype none
module slot_status_devcap2_regs_checker (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // select
  input wire logic penable, // access
  input wire logic pwrite, // direction
  input wire logic [7:0] paddr, // address
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr // error
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd = pready && !pwrite;
  wire mapped = paddr inside {8'hd4, 8'hd8, 8'he4, 8'he8, 8'hec, 8'hf0, 8'hf4, 8'hf8};
  // one wait state, then a single-cycle answer
  ready_timing_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("pready not one cycle after access");
  no_request_a: assert property (!psel |=> !pready) else $error("pready without request");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  unmapped_err_a: assert property (pready |-> (pslverr == !mapped)) else $error("pslverr wrong for address");
  cap2_value_a: assert property (rd && paddr == 8'he4 |-> prdata[11] && prdata[31:20] == 12'h000 &&
    prdata[17:13] == 5'h00 && prdata[10:0] == 11'h000) else $error("devcap2 fixed fields wrong");
  ctl2_reserved_a: assert property (rd && paddr == 8'he8 |-> prdata[31:15] == 17'h00000 &&
    prdata[12:11] == 2'h0 && prdata[9:0] == 10'h000) else $error("devctl2 reserved bits set");
  lcap2_zero_a: assert property (rd && paddr == 8'hec |-> prdata == 32'h00000000)
    else $error("linkcap2 not zero");
  slot_reserved_a: assert property (rd && paddr == 8'hd8 |-> prdata[15:0] == 16'h0000 &&
    !prdata[23] && prdata[31:25] == 7'h00) else $error("slot status reserved bits set");
endmodule // slot_status_devcap2_regs_checker
`default_nettype wire
bind slot_status_devcap2_regs slot_status_devcap2_regs_checker chk_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr));

// File: verif/slot_status_devcap2_regs_tb.sv
// self-checking bench for the slot status register block
// assumes one 100 mhz clock; sensors come from the slot_sensors model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module slot_status_devcap2_regs_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err, hp_irq, irq, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, rd, prdata;
  logic [6:0] sens;
  int failures = 0, check_count = 0;
  slot_sensors slot_sensors_i (.pclk(pclk), .sens(sens));
  slot_status_devcap2_regs slot_status_devcap2_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .button_in(sens[0]), .pwr_fault_in(sens[1]), .latch_open_in(sens[2]),
    .card_present_in(sens[3]), .cmd_done_in(sens[4]), .link_active_in(sens[5]), .slot_impl_in(sens[6]),
    .hp_irq(hp_irq), .irq(irq));
  initial forever #5 pclk = ~pclk;
  task automatic test_done;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one apb transfer; an idle cycle always follows
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk) begin psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; end
    @(posedge pclk) penable <= 1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin failures++; test_done(); end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // reset values and the unmapped refusal
  task automatic t_reset;
    xfer(0, 8'hd8, 0); `CHK(rd, 32'h00000000)
    xfer(0, 8'he4, 0); `CHK(rd, 32'h00000800)
    xfer(0, 8'he8, 0); `CHK(rd, 32'h00000000)
    xfer(1, 8'hec, 32'hffffffff); xfer(0, 8'hec, 0); `CHK(rd, 32'h00000000)
    xfer(1, 8'h00, 32'hffffffff); xfer(0, 8'h00, 0); `CHK({err, rd}, {1'b1, 32'h0})
  endtask
  // every event, then zero and one writes; latch flag is read-only
  task automatic t_events;
    slot_sensors_i.pulse(0); slot_sensors_i.pulse(1); slot_sensors_i.pulse(4);
    slot_sensors_i.setl(2, 1); slot_sensors_i.setl(3, 1); slot_sensors_i.setl(5, 1);
    idle(8);
    xfer(0, 8'hd8, 0); `CHK(rd, 32'h017f0000)
    xfer(1, 8'hd8, 0); xfer(0, 8'hd8, 0); `CHK(rd, 32'h017f0000)
    xfer(1, 8'hd8, 32'hffffffff); xfer(0, 8'hd8, 0); `CHK(rd, 32'h00640000)
  endtask
  // control fields writable, capabilities not, override loads
  task automatic t_ctl2;
    xfer(1, 8'he8, 32'hffffffff); xfer(0, 8'he8, 0); `CHK(rd, 32'h00006400)
    xfer(1, 8'he4, 32'hffffffff); xfer(0, 8'he4, 0); `CHK(rd, 32'h00000800)
    xfer(1, 8'hf8, 32'h000c1000); xfer(0, 8'he4, 0); `CHK(rd, 32'h000c1800)
  endtask
  // presence state follows the card, forced high with no slot
  task automatic t_noslot;
    slot_sensors_i.setl(3, 0); idle(8);
    xfer(0, 8'hd8, 0); `CHK(rd[22], 1'b0)
    slot_sensors_i.setl(6, 0); idle(8);
    xfer(0, 8'hd8, 0); `CHK(rd[22], 1'b1)
  endtask
  // hot-plug needs the global enable; summary irq obeys mask and clear
  task automatic t_irq;
    slot_sensors_i.pulse(0); idle(8);
    xfer(1, 8'hd4, 32'h00000001); xfer(1, 8'hf4, 0); idle(3);
    `CHK({hp_irq, irq}, 2'b00)
    xfer(1, 8'hd4, 32'h00000021); xfer(1, 8'hf4, 32'h00000001); idle(3);
    `CHK({hp_irq, irq}, 2'b11)
    xfer(1, 8'hf0, 32'h0000003f); idle(3); `CHK(irq, 1'b0)
    xfer(1, 8'hd8, 32'h00010000); idle(3); `CHK(hp_irq, 1'b0)
  endtask
  // sensors back to idle, then a mid-run reset clears every flag, the latch flag too
  task automatic t_rerst;
    slot_sensors_i.setl(2, 0); slot_sensors_i.setl(5, 0); slot_sensors_i.setl(6, 1); idle(8);
    presetn <= 0;
    idle(2);
    presetn <= 1;
    idle(10);
    `CHK({hp_irq, irq}, 2'b00)
    xfer(0, 8'hd8, 0); `CHK(rd, 32'h00000000)
    xfer(0, 8'hf0, 0); `CHK(rd, 32'h00000000)
  endtask
  initial begin
    idle(16);
    presetn <= 1;
    idle(10);
    t_reset(); t_events(); t_ctl2(); t_noslot(); t_irq(); t_rerst();
    test_done();
  end
endmodule // slot_status_devcap2_regs_tb
`default_nettype wire
